// File: rtl/wdog_pkg.sv
// constants, timing counts and carriers for the window watchdog
// assumes a 20 MHz reference clock and a 1 us internal tick
package wdog_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_US = 1;
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int DIV_W = 5;
   localparam int CNT_W = 22;
   localparam int WIN_SHORT_MS = 250;
   localparam int WIN_LONG_MS = 2500;
   localparam int WIN_CAP_US = 6250;
   localparam int RST_DELAY_MS = 25;
   localparam int WIN_SHORT_TICKS = WIN_SHORT_MS * 1000 / TICK_US;
   localparam int WIN_LONG_TICKS = WIN_LONG_MS * 1000 / TICK_US;
   localparam int WIN_CAP_TICKS = WIN_CAP_US / TICK_US;
   localparam int RST_TICKS = RST_DELAY_MS * 1000 / TICK_US;
   // window-to-lower-boundary ratios, scaled by ten
   localparam int RATIO_HI_SHORT = 1249;
   localparam int RATIO_HI_LONG = 1277;
   localparam int RATIO_HI_CAP = 645;
   localparam int RATIO_LO_SHORT = 318;
   localparam int RATIO_LO_LONG = 320;
   localparam int RATIO_LO_CAP = 258;
   localparam int RATIO_SCALE = 10;
   localparam int NPINS = 4;
   localparam int PIN_TRIG = 3;

   typedef struct packed {
      logic timeout_cap;
      logic timeout_high;
      logic ratio_high;
   } strap_t;

   typedef enum logic [1:0] {
      ST_FIRST = 2'b00,
      ST_RUN = 2'b01,
      ST_HOLD = 2'b11
   } wd_state_t;
endpackage : wdog_pkg

// File: rtl/pin_filter.sv
// three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk
`timescale 1ns/10ps
`default_nettype none
module pin_filter
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pin and filtered level
   input wire logic pin_in,
   output logic level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         level <= 1'b0;
      else if (s2_reg == s3_reg)
         level <= s3_reg;
   end
endmodule : pin_filter
`default_nettype wire

// File: rtl/window_watchdog_core.sv
// window watchdog core: trigger window check and reset output
// assumes strap pins are static ties and the reset pin is open drain
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - a trigger rising edge is caught at any time but acted on at the next internal tick.
// - ratio high with short timeout puts the lower boundary at window over 124.9.
// - ratio high with long timeout puts the lower boundary at window over 127.7.
// - ratio high with capacitor timeout puts the lower boundary at window over 64.5.
// - ratio low with short timeout puts the lower boundary at window over 31.8.
// - ratio low with long timeout puts the lower boundary at window over 32.
// - ratio low with capacitor timeout puts the lower boundary at window over 25.8.
// - the timeout is 0.25 s or 2.5 s by strap, or capacitor set when one is fitted.
// - timeout strap high gives a 2.5 s window while the capacitor strap is low.
// - timeout strap low gives a 0.25 s window while the capacitor strap is low.
// - each trigger edge that is not early and not in the reset hold restarts the window and clears the timers.
// - the first window after reset has no lower boundary; later ones do.
module window_watchdog_core
   import wdog_pkg::*;
#(
   parameter int WIN_SHORT = wdog_pkg::WIN_SHORT_TICKS,
   parameter int WIN_LONG = wdog_pkg::WIN_LONG_TICKS,
   parameter int WIN_CAP = wdog_pkg::WIN_CAP_TICKS,
   parameter int RST_HOLD = wdog_pkg::RST_TICKS
)
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   // processor trigger and strap pins
   input wire logic TRIGGER_INPUT,
   input wire wdog_pkg::strap_t STRAPS,
   // open-drain reset pin
   output logic RST_OUT,
   output logic RST_OE_N
);
   import wdog_pkg::*;

   logic [NPINS-1:0] pins;
   logic [NPINS-1:0] pins_f;
   logic trig_prev_reg;
   logic pend_reg;
   logic tick_reg;
   logic [DIV_W-1:0] div_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_inc;
   logic [CNT_W-1:0] win_reg;
   logic [CNT_W-1:0] lower_reg;
   logic [CNT_W-1:0] win_next;
   logic [CNT_W-1:0] lower_next;
   wd_state_t state_reg;
   logic trig_rise;
   logic early;
   logic expire;

   assign pins = {TRIGGER_INPUT, STRAPS};

   genvar g;
   generate
      for (g = 0; g < NPINS; g++)
      begin : g_pin
         pin_filter u_filt
         (
            .clk(REF_CLK),
            .rst_n(RESETN),
            .pin_in(pins[g]),
            .level(pins_f[g])
         );
      end
   endgenerate

   // free-running internal oscillator as a tick enable
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end
      else if (div_reg == DIV_W'(TICK_CYC - 1))
      begin
         div_reg <= '0;
         tick_reg <= 1'b1;
      end
      else
      begin
         div_reg <= div_reg + 1'b1;
         tick_reg <= 1'b0;
      end
   end

   assign trig_rise = pins_f[PIN_TRIG] & ~trig_prev_reg;

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         trig_prev_reg <= 1'b0;
      else
         trig_prev_reg <= pins_f[PIN_TRIG];
   end

   // edge held until the next tick; a new edge wins over the clear
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
         pend_reg <= 1'b0;
      else if (trig_rise)
         pend_reg <= 1'b1;
      else if (tick_reg)
         pend_reg <= 1'b0;
   end

   // window and boundary from the straps
   always_comb
   begin
      win_next = CNT_W'(WIN_SHORT);
      lower_next = CNT_W'(WIN_SHORT * RATIO_SCALE / RATIO_LO_SHORT);
      if (pins_f[2])
      begin
         win_next = CNT_W'(WIN_CAP);
         if (pins_f[0])
            lower_next = CNT_W'(WIN_CAP * RATIO_SCALE / RATIO_HI_CAP);
         else
            lower_next = CNT_W'(WIN_CAP * RATIO_SCALE / RATIO_LO_CAP);
      end
      else if (pins_f[1])
      begin
         win_next = CNT_W'(WIN_LONG);
         if (pins_f[0])
            lower_next = CNT_W'(WIN_LONG * RATIO_SCALE / RATIO_HI_LONG);
         else
            lower_next = CNT_W'(WIN_LONG * RATIO_SCALE / RATIO_LO_LONG);
      end
      else if (pins_f[0])
         lower_next = CNT_W'(WIN_SHORT * RATIO_SCALE / RATIO_HI_SHORT);
   end

   // straps followed during the first window, frozen after
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         win_reg <= CNT_W'(WIN_SHORT);
         lower_reg <= '0;
      end
      else if (tick_reg && state_reg == ST_FIRST)
      begin
         win_reg <= win_next;
         lower_reg <= lower_next;
      end
   end

   assign cnt_inc = cnt_reg + 1'b1;
   assign early = pend_reg && state_reg == ST_RUN && cnt_reg < lower_reg;
   assign expire = !pend_reg && cnt_inc >= win_reg;

   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state_reg <= ST_FIRST;
         cnt_reg <= '0;
      end
      else if (tick_reg)
      begin
         unique case (state_reg)
            ST_FIRST, ST_RUN:
            begin
               if (early || expire)
               begin
                  state_reg <= ST_HOLD;
                  cnt_reg <= '0;
               end
               else if (pend_reg)
               begin
                  state_reg <= ST_RUN;
                  cnt_reg <= '0;
               end
               else
                  cnt_reg <= cnt_inc;
            end
            ST_HOLD:
            begin
               if (cnt_inc >= CNT_W'(RST_HOLD))
               begin
                  state_reg <= ST_FIRST;
                  cnt_reg <= '0;
               end
               else
                  cnt_reg <= cnt_inc;
            end
            default:
            begin
               state_reg <= ST_HOLD;
               cnt_reg <= '0;
            end
         endcase
      end
   end

   // open drain: only ever pulls low, enable low while pulling
   always_ff @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         RST_OUT <= 1'b0;
         RST_OE_N <= 1'b1;
      end
      else if (tick_reg)
      begin
         RST_OUT <= 1'b0;
         if (state_reg != ST_HOLD && (early || expire))
            RST_OE_N <= 1'b0;
         else if (state_reg == ST_HOLD && cnt_inc >= CNT_W'(RST_HOLD))
            RST_OE_N <= 1'b1;
      end
   end

   a_tick_only_act: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      !tick_reg |=> $stable(cnt_reg) && $stable(state_reg))
      else $error("counter moved off a tick");
   a_edge_restart: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && pend_reg && state_reg != ST_HOLD |=> cnt_reg == '0)
      else $error("trigger did not clear the timer");
   a_first_no_lower: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && pend_reg && state_reg == ST_FIRST && !expire
      |=> state_reg == ST_RUN && RST_OE_N)
      else $error("first window enforced a lower boundary");
   a_early_reset: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && early |=> state_reg == ST_HOLD && !RST_OE_N)
      else $error("early trigger did not assert reset");
   a_timeout_reset: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && state_reg != ST_HOLD && !pend_reg && cnt_inc >= win_reg
      |=> !RST_OE_N)
      else $error("timeout did not assert reset");
   a_hold_release: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && state_reg == ST_HOLD && cnt_inc >= CNT_W'(RST_HOLD)
      |=> state_reg == ST_FIRST && RST_OE_N)
      else $error("reset not released after delay");
   a_hold_drives: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      state_reg == ST_HOLD |-> !RST_OE_N && !RST_OUT)
      else $error("reset pin released during hold");
   a_window_short: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && state_reg == ST_FIRST && pins_f[2:1] == 2'h0
      |=> win_reg == CNT_W'(WIN_SHORT))
      else $error("short window not selected");
   a_window_long: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && state_reg == ST_FIRST && pins_f[2:1] == 2'h1
      |=> win_reg == CNT_W'(WIN_LONG))
      else $error("long window not selected");
   a_lower_ratio: assert property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && state_reg == ST_FIRST && pins_f[2:0] == 3'h1
      |=> lower_reg == CNT_W'(WIN_SHORT * RATIO_SCALE / RATIO_HI_SHORT))
      else $error("wrong lower boundary");

   c_good_trigger: cover property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && pend_reg && state_reg == ST_RUN && !early);
   c_early: cover property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && early);
   c_timeout: cover property (@(posedge REF_CLK) disable iff (!RESETN)
      tick_reg && state_reg == ST_RUN && expire);
endmodule : window_watchdog_core
`default_nettype wire

// File: test/proc_model.sv
// processor model: drives trigger pulses on request
// assumes the bench clock; the trigger pin is push-pull
`timescale 1ns/10ps
`default_nettype none
module proc_model
(
   // clock
   input wire logic clk,
   // trigger pin
   output logic trig
);
   initial trig = 1'b0;
   // rise gap clocks after the call, stay high 4 clocks
   // callers pick the gap per pulse; s_restart gives the same gap to two pulses in a row
   task automatic pulse(input int gap);
      repeat (gap) @(posedge clk);
      trig <= 1'b1;
      repeat (4) @(posedge clk);
      trig <= 1'b0;
   endtask : pulse
endmodule : proc_model
`default_nettype wire

// File: test/tb.sv
// bench for the window watchdog core with a processor model
// assumes short window parameters; the reset pin has a pull-up
`timescale 1ns/10ps
`default_nettype none
module tb;
   import wdog_pkg::*;
   localparam int WS = 625;
   localparam int WL = 1277;
   localparam int WC = 323;
   localparam int RH = 50;
   logic ref_clk;
   logic resetn;
   strap_t straps;
   logic rst_out;
   logic rst_oe_n;
   logic trig;
   logic reset_pin;
   int n_mismatch;
   int check_count;
   // released open drain reads high through the pull-up
   assign reset_pin = rst_oe_n ? 1'b1 : rst_out;
   window_watchdog_core #(.WIN_SHORT(WS), .WIN_LONG(WL), .WIN_CAP(WC),
      .RST_HOLD(RH)) window_watchdog_core_inst (.REF_CLK(ref_clk),
      .RESETN(resetn), .TRIGGER_INPUT(trig), .STRAPS(straps),
      .RST_OUT(rst_out), .RST_OE_N(rst_oe_n));
   proc_model proc_model_inst (.clk(ref_clk), .trig(trig));
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic close_out;
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic chk(input int v, input int lo, input int hi, string m);
      check_count++;
      if (v < lo || v > hi)
      begin
         $display("mismatch %0t %s", $time, m);
         n_mismatch++;
      end
   endtask : chk
   // pin levels compared as four-state so an unknown never passes
   task automatic chk_pin(input logic v, input logic e, input string m);
      check_count++;
      if (v !== e)
      begin
         $display("mismatch %0t %s", $time, m);
         n_mismatch++;
      end
   endtask : chk_pin
   task automatic restart(input strap_t s);
      @(posedge ref_clk);
      resetn <= 1'b0;
      straps <= s;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask : restart
   // clocks until reset is pulled low, n if it never is
   task automatic wait_low(input int n, output int k);
      k = 0;
      while (rst_oe_n !== 1'b0 && k < n)
      begin
         // falling edge: outputs launched at the rising edge have settled
         @(negedge ref_clk);
         k++;
      end
   endtask : wait_low
   // lower boundary per strap setting, early and late trigger
   task automatic s_boundary;
      strap_t s;
      int w;
      int lo;
      int k;
      for (int i = 0; i < 6; i++)
      begin
         s = strap_t'(3'(i / 3 * 4 + i % 3 * 2 + 1));
         if (i % 3 == 2)
            s = strap_t'(3'(i / 3 * 4));
         s.timeout_cap = (i % 3 == 2);
         s.timeout_high = (i % 3 == 1);
         s.ratio_high = (i < 3);
         w = s.timeout_cap ? WC : (s.timeout_high ? WL : WS);
         lo = w * RATIO_SCALE / (s.timeout_cap ? (s.ratio_high ?
            RATIO_HI_CAP : RATIO_LO_CAP) : s.timeout_high ? (s.ratio_high
            ? RATIO_HI_LONG : RATIO_LO_LONG) : (s.ratio_high ?
            RATIO_HI_SHORT : RATIO_LO_SHORT));
         restart(s);
         proc_model_inst.pulse(40);
         proc_model_inst.pulse((lo - 2) * 20 - 4);
         wait_low(30, k);
         chk(k, 0, 29, "early trigger not caught");
         chk_pin(reset_pin, 1'b0, "reset pin not low");
         k = 0;
         while (rst_oe_n === 1'b0 && k < RH * 20 + 60)
         begin
            @(negedge ref_clk);
            k++;
         end
         chk(k, RH * 20 - 25, RH * 20 + 25, "hold length");
         chk_pin(reset_pin, 1'b1, "reset pin not released");
         proc_model_inst.pulse(20);
         wait_low(60, k);
         chk(k, 60, 60, "first window after hold");
         restart(s);
         proc_model_inst.pulse(40);
         proc_model_inst.pulse((lo + 2) * 20 - 4);
         wait_low(60, k);
         chk(k, 60, 60, "late trigger refused");
      end
   endtask : s_boundary
   // upper timeout for each timeout strap
   task automatic s_timeout;
      int w;
      int k;
      for (int i = 0; i < 3; i++)
      begin
         w = (i == 0) ? WS : (i == 1) ? WL : WC;
         restart(strap_t'(3'(i == 2 ? 4 : i * 2)));
         proc_model_inst.pulse(40);
         wait_low(w * 20 + 100, k);
         chk(k + 4, w * 20 - 80, w * 20 + 60, "timeout");
      end
   endtask : s_timeout
   // each trigger restarts the window
   task automatic s_restart;
      int k;
      restart(strap_t'(3'h4));
      proc_model_inst.pulse(40);
      proc_model_inst.pulse(WC * 15 - 4);
      proc_model_inst.pulse(WC * 15 - 4);
      wait_low(WC * 10, k);
      chk(k, WC * 10, WC * 10, "window not restarted");
   endtask : s_restart
   initial
   begin
      resetn = 1'b0;
      straps = strap_t'(3'h0);
      n_mismatch = 0;
      check_count = 0;
      s_boundary();
      s_timeout();
      s_restart();
      close_out();
   end
   // the full run needs about 70000 clocks
   initial
   begin
      #5_000_000;
      n_mismatch++;
      close_out();
   end
endmodule : tb
`default_nettype wire
